// [design/rdwb_cfg.svh]
`ifndef RDWB_CFG_SVH
`define RDWB_CFG_SVH
// Overview of operation
// - store data at address, then write quadword two
// - length counts buffer bytes including crc
// - ones complement sum after ip header
// - status byte bit layout fixed
// - never done zero with last one
// - vlan flag on ethertype match and mode
// - checksum done bits only with offload
// - no ipv4 done bit for ipv6
// - inexact flag on hash-only match
// - clear inexact for promiscuous or broadcast
// - inexact on forwarded unmatched control frame
// - error byte bits seven six five
// - checksum error bits valid only with done flags
// - checksum errors zero without offload
// - data error causes, post only if storing
// - record tag, strip four bytes, else zero
// - tag layout urgency, format bit, identifier
// - advanced read layout with bit zero
// - header address only in first descriptor
// - type zero selects legacy format

// ****************************************************************
// register offsets
// ****************************************************************
`define RDWB_REG_CTRL       4'h0
`define RDWB_REG_VLAN_TYPE  4'h1
`define RDWB_REG_STATUS     4'h2
`define RDWB_REG_COUNT      4'h3
// control register fields
`define RDWB_CTRL_VLAN_MODE 0
`define RDWB_CTRL_MC_ALL    1
`define RDWB_CTRL_BC_ACC    2
`define RDWB_CTRL_PASS_CTRL 3
`define RDWB_CTRL_STORE_BAD 4
`define RDWB_CTRL_IP_OFFLOAD 5
`define RDWB_CTRL_L4_OFFLOAD 6
`define RDWB_CTRL_NSSEL     7
`define RDWB_CTRL_DT_LO     8
`define RDWB_CTRL_DT_HI     10
`define RDWB_CTRL_RESET     32'h0000_0000
`define RDWB_VLAN_RESET     16'h8100
// descriptor field positions in the second quadword
`define RDWB_LEN_LSB        0
`define RDWB_CSUM_LSB       16
`define RDWB_STAT_LSB       32
`define RDWB_ERR_LSB        40
`define RDWB_TAG_LSB        48
// status bits
`define RDWB_ST_INEXACT     7
`define RDWB_ST_IP_DONE     6
`define RDWB_ST_L4_DONE     5
`define RDWB_ST_UDP_DONE    4
`define RDWB_ST_VLAN        3
`define RDWB_ST_LAST        1
`define RDWB_ST_DONE        0
// error bits
`define RDWB_ER_DATA        7
`define RDWB_ER_IP          6
`define RDWB_ER_L4          5
`define RDWB_TAG_BYTES      16'h0004
`define RDWB_TAG_NONE       16'h0000
`endif

// [design/rdwb_engine.sv]
`timescale 1ns/100ps
`include "rdwb_cfg.svh"
module rdwb_engine
  import rdwb_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           sys_rst,
  // register port
  input  wire logic [3:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_write,
  input  wire logic           reg_read,
  output logic [31:0]         reg_rdata,
  // descriptor handed in by the fetch logic
  input  wire logic           desc_valid,
  input  wire logic [63:0]    desc_word0,
  input  wire logic [63:0]    desc_word1,
  output logic                desc_ready,
  // received data and classification
  input  wire rdwb_beat_type  rx_beat,
  input  wire logic           rx_buf_full,
  input  wire rdwb_class_type rx_class,
  output logic                rx_ready,
  // memory writes
  output rdwb_wr_type         mem_wr,
  input  wire logic           mem_ready,
  input  wire logic           mem_committed,
  // header buffer address for split logic
  output logic [63:0]         hdr_addr,
  output logic                hdr_addr_valid
);

  rdwb_state_all_type s;
  rdwb_state_all_type next_s;

  logic       vlan_hit;
  logic       dtype_legacy;
  logic [7:0] status_byte;
  logic [7:0] error_byte;
  logic       rx_err;
  logic       ip_off;
  logic       tu_off;
  logic       inexact;
  logic       ip_known;
  logic [16:0] sum_step;
  logic [15:0] beat_bytes;

  // ****************************************************************
  // per-packet descriptor fields
  // ****************************************************************
  always_comb begin
    ip_off       = s.ctrl[`RDWB_CTRL_IP_OFFLOAD];
    tu_off       = s.ctrl[`RDWB_CTRL_L4_OFFLOAD];
    ip_known     = rx_class.is_ipv4 || rx_class.is_ipv6;
    dtype_legacy = (s.ctrl[`RDWB_CTRL_DT_HI:`RDWB_CTRL_DT_LO]
                    == 3'h0);
    vlan_hit     = s.ctrl[`RDWB_CTRL_VLAN_MODE]
                   && (rx_class.ether_type == s.vlan_type);
    rx_err = rx_class.crc_err | rx_class.code_err | rx_class.mii_err
             | rx_class.bad_delim | rx_class.sync_loss;
    // hash-only pass is inexact; promiscuous/broadcast accept clears
    inexact = ((rx_class.hash_match
                || (rx_class.is_ctrl_frame
                    && !s.ctrl[`RDWB_CTRL_PASS_CTRL]))
               && !rx_class.exact_match)
              && !(rx_class.is_mcast && s.ctrl[`RDWB_CTRL_MC_ALL])
              && !(rx_class.is_bcast && s.ctrl[`RDWB_CTRL_BC_ACC]);
    status_byte = 8'h00;
    error_byte  = 8'h00;
    if (s.last) begin
      status_byte[`RDWB_ST_INEXACT] = inexact;
      // never for ipv6, never without offload
      status_byte[`RDWB_ST_IP_DONE] = ip_off && rx_class.is_ipv4
                                      && !rx_class.is_ipv6
                                      && !(rx_class.is_udp
                                           && rx_class.udp_zero_csum);
      // unknown network layer gets no transport check
      status_byte[`RDWB_ST_L4_DONE] = tu_off && rx_class.is_tcp
                                      && ip_known;
      status_byte[`RDWB_ST_UDP_DONE] = tu_off && rx_class.is_udp && ip_known
                                       && !(rx_class.is_ipv4
                                            && rx_class.udp_zero_csum);
      status_byte[`RDWB_ST_VLAN] = vlan_hit;
      // errors only on a completed last buffer
      error_byte[`RDWB_ER_DATA] = rx_err;
      error_byte[`RDWB_ER_IP]   = status_byte[`RDWB_ST_IP_DONE]
                                  && rx_class.ip_csum_bad;
      error_byte[`RDWB_ER_L4]   = (status_byte[`RDWB_ST_L4_DONE]
                                   || status_byte[`RDWB_ST_UDP_DONE])
                                  && rx_class.l4_csum_bad;
    end
    // done always set, so last never shows without done
    status_byte[`RDWB_ST_LAST] = s.last;
    status_byte[`RDWB_ST_DONE] = 1'b1;
    beat_bytes = rx_beat.odd ? 16'h0001 : 16'h0002;
    sum_step = {1'b0, s.csum[15:0]} + {1'b0, rx_beat.data}
               + {16'h0000, s.csum[16]};
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s         = s;
    next_s.wr.valid = s.wr.valid && !mem_ready;
    next_s.rdata   = 32'h0000_0000;
    desc_ready     = (s.state == RDWB_IDLE);
    rx_ready       = (s.state == RDWB_DATA) && !s.wr.valid;
    if (reg_write) begin
      case (reg_addr)
        `RDWB_REG_CTRL:      next_s.ctrl = reg_wdata;
        `RDWB_REG_VLAN_TYPE: next_s.vlan_type = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `RDWB_REG_CTRL:      next_s.rdata = s.ctrl;
        `RDWB_REG_VLAN_TYPE: next_s.rdata = {16'h0000, s.vlan_type};
        `RDWB_REG_STATUS:
          next_s.rdata = {29'h0, s.first, s.state == RDWB_IDLE, s.drop};
        `RDWB_REG_COUNT:     next_s.rdata = s.pkt_count;
        default:             next_s.rdata = 32'h0000_0000;
      endcase
    end
    case (s.state)
      RDWB_IDLE: begin
        if (desc_valid) begin
          // bit zero is no-snoop or address, per queue select
          next_s.no_snoop = s.ctrl[`RDWB_CTRL_NSSEL]
                            && desc_word0[0];
          next_s.pkt_addr = s.ctrl[`RDWB_CTRL_NSSEL]
                            ? {desc_word0[63:1], 1'b0} : desc_word0;
          next_s.len      = 16'h0000;
          next_s.last     = 1'b0;
          next_s.state    = RDWB_DATA;
        end
      end
      RDWB_DATA: begin
        if (rx_beat.valid && rx_ready) begin
          // stripped tag bytes are neither stored nor counted
          if (!(rx_beat.is_tag && vlan_hit)) begin
            next_s.wr.valid    = 1'b1;
            next_s.wr.addr     = s.pkt_addr;
            next_s.wr.data     = {48'h0, rx_beat.data};
            next_s.wr.no_snoop = s.no_snoop;
            next_s.wr.is_desc  = 1'b0;
            next_s.pkt_addr    = s.pkt_addr + 64'(beat_bytes);
            next_s.len         = s.len + beat_bytes;
          end
          if (rx_beat.in_l4 && !rx_beat.is_crc) begin
            next_s.csum = sum_step;
          end
          if (rx_beat.last || rx_buf_full) begin
            next_s.last  = rx_beat.last;
            next_s.state = RDWB_WAIT;
          end
        end
      end
      RDWB_WAIT: begin
        // hold done until data is committed in host memory
        if (!s.wr.valid && mem_committed) begin
          next_s.drop    = s.last && rx_err
                           && !s.ctrl[`RDWB_CTRL_STORE_BAD];
          next_s.wb_word = '0;
          next_s.wb_word[`RDWB_LEN_LSB +: 16]  = s.len;
          // a partial sum is meaningless on a non-last buffer
          next_s.wb_word[`RDWB_CSUM_LSB +: 16] =
            s.last ? s.csum[15:0] + {15'h0, s.csum[16]} : 16'h0000;
          next_s.wb_word[`RDWB_STAT_LSB +: 8]  = status_byte;
          next_s.wb_word[`RDWB_ERR_LSB +: 8]   = error_byte;
          next_s.wb_word[`RDWB_TAG_LSB +: 16]  =
            (s.last && vlan_hit) ? rx_class.tag
                                 : `RDWB_TAG_NONE;
          next_s.state = RDWB_DESC;
        end
      end
      RDWB_DESC: begin
        if (!s.wr.valid) begin
          if (!s.drop) begin
            next_s.wr.valid    = 1'b1;
            next_s.wr.addr     = 64'h0000_0000_0000_0008;
            next_s.wr.data     = s.wb_word;
            next_s.wr.no_snoop = 1'b0;
            next_s.wr.is_desc  = 1'b1;
          end
          if (s.last) begin
            next_s.first     = 1'b1;
            next_s.csum      = 17'h0;
            next_s.pkt_count = s.pkt_count + 32'h1;
          end else begin
            next_s.first = 1'b0;
          end
          next_s.drop  = 1'b0;
          next_s.state = RDWB_IDLE;
        end
      end
      default: next_s.state = RDWB_IDLE;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s           <= '0;
      s.state     <= RDWB_IDLE;
      s.ctrl      <= `RDWB_CTRL_RESET;
      s.vlan_type <= `RDWB_VLAN_RESET;
      s.first     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // header address is only used by the first buffer of a packet
  always_comb begin
    reg_rdata      = s.rdata;
    mem_wr         = s.wr;
    hdr_addr       = {desc_word1[63:1], 1'b0};
    hdr_addr_valid = desc_valid && desc_ready && s.first
                     && !dtype_legacy;
  end

endmodule

// [design/rdwb_pkg.sv]
package rdwb_pkg;
  // one received data beat, sixteen bits, from the mac side
  typedef struct packed {
    logic        valid;
    logic        last;
    logic        odd;      // only high byte of last beat valid
    logic [15:0] data;
    logic        in_l4;    // beat lies after the ip header
    logic        is_crc;   // beat carries crc bytes
    logic        is_tag;   // beat carries vlan tag words
  } rdwb_beat_type;

  // per-packet classification, held from the first beat through the write-back
  typedef struct packed {
    logic [15:0] ether_type;
    logic [15:0] tag;
    logic        is_ipv4;
    logic        is_ipv6;
    logic        is_tcp;
    logic        is_udp;
    logic        udp_zero_csum;
    logic        ip_csum_bad;
    logic        l4_csum_bad;
    logic        is_mcast;
    logic        is_bcast;
    logic        exact_match;
    logic        hash_match;
    logic        is_ctrl_frame;
    logic        crc_err;
    logic        code_err;
    logic        mii_err;
    logic        bad_delim;
    logic        sync_loss;
  } rdwb_class_type;

  // memory write request towards the system bus
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
    logic [63:0] data;
    logic        no_snoop;
    logic        is_desc;
  } rdwb_wr_type;

  typedef enum logic [1:0] {
    RDWB_IDLE,
    RDWB_DATA,
    RDWB_WAIT,
    RDWB_DESC
  } rdwb_state_type;

  typedef struct packed {
    rdwb_state_type state;
    logic [31:0]    ctrl;
    logic [15:0]    vlan_type;
    logic [31:0]    rdata;
    logic [31:0]    pkt_count;
    logic [15:0]    len;
    logic [16:0]    csum;
    logic [63:0]    pkt_addr;
    logic           no_snoop;
    logic           first;
    logic           last;
    logic           drop;
    logic [63:0]    wb_word;
    rdwb_wr_type    wr;
  } rdwb_state_all_type;
endpackage

// [verif/rdwb_engine_assertions.sv]
`timescale 1ns/100ps
module rdwb_engine_assertions
  import rdwb_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           sys_rst,
  // watched ports
  input  wire rdwb_wr_type    mem_wr,
  input  wire logic           mem_ready,
  input  wire logic           mem_committed,
  input  wire rdwb_class_type rx_class
);
  // ****************************************************************
  // write-back checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [63:0] d;
  logic        w;
  assign d = mem_wr.data;
  assign w = mem_wr.valid && mem_wr.is_desc;
  property p_hold;
    mem_wr.valid && !mem_ready |=> mem_wr.valid && $stable(mem_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("write changed early");
  property p_done;
    w |-> d[32];
  endproperty
  a_done: assert property (p_done) else $error("done flag clear");
  property p_nonlast;
    w && !d[33] |-> d[63:32] == 32'h1 && d[31:16] == 16'h0;
  endproperty
  a_nonlast: assert property (p_nonlast) else $error("non-last fields");
  property p_rsvd;
    w |-> !d[34] && d[44:40] == 5'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_errs;
    w && d[33] |-> (!d[46] || d[38]) && (!d[45] || d[37] || d[36]);
  endproperty
  a_errs: assert property (p_errs) else $error("error without check");
  property p_tag;
    w && d[33] && !d[35] |-> d[63:48] == 16'h0;
  endproperty
  a_tag: assert property (p_tag) else $error("tag not zero");
  property p_ipv4;
    w && d[38] |-> rx_class.is_ipv4 && !rx_class.is_ipv6;
  endproperty
  a_ipv4: assert property (p_ipv4) else $error("ipv4 done wrongly");
  property p_commit;
    $rose(w) |-> $past(mem_committed);
  endproperty
  a_commit: assert property (p_commit) else $error("done before commit");
endmodule
bind rdwb_engine rdwb_engine_assertions u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .mem_wr(mem_wr), .mem_ready(mem_ready),
  .mem_committed(mem_committed), .rx_class(rx_class));

// [verif/rdwb_mem_model.sv]
`timescale 1ns/100ps
module rdwb_mem_model
  import rdwb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // write port
  input  wire rdwb_wr_type mem_wr,
  input  wire logic        slow,
  output logic             mem_ready,
  output logic             mem_committed
);
  // ****************************************************************
  // host memory
  // ****************************************************************
  logic [2:0] age;
  // a posted write needs seven quiet cycles before it counts as landed
  assign mem_committed = (age == 3'h7);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ready <= 1'b0;
      age <= 3'h7;
    end else begin
      mem_ready <= !slow || ($urandom_range(1) == 1);
      if (mem_wr.valid && mem_ready && !mem_wr.is_desc)
        age <= 3'h0;
      else if (age != 3'h7)
        age <= age + 3'h1;
    end
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import rdwb_pkg::*;
  // ****************************************************************
  // bench
  // ****************************************************************
  logic           mclk, sys_rst, reg_write, reg_read, desc_valid, slow;
  logic           desc_ready, rx_buf_full, rx_ready, mem_ready, rd_q;
  logic           mem_committed, hdr_addr_valid, exp_ns, first;
  logic [3:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, ctrl;
  logic [63:0]    desc_word0, desc_word1, hdr_addr, e, r;
  logic [16:0]    s;
  logic [15:0]    vt;
  rdwb_beat_type  rx_beat;
  rdwb_class_type rx_class, c;
  rdwb_wr_type    mem_wr;
  logic [63:0]    rq[$], dq[$];
  logic [79:0]    wq[$], f;
  int             n_errors = 0, num_checks = 0, cyc = 0;
  rdwb_engine uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .desc_valid(desc_valid),
    .desc_word0(desc_word0), .desc_word1(desc_word1),
    .desc_ready(desc_ready), .rx_beat(rx_beat), .rx_buf_full(rx_buf_full),
    .rx_class(rx_class), .rx_ready(rx_ready), .mem_wr(mem_wr),
    .mem_ready(mem_ready), .mem_committed(mem_committed),
    .hdr_addr(hdr_addr), .hdr_addr_valid(hdr_addr_valid));
  rdwb_mem_model u_mem (.mclk(mclk), .sys_rst(sys_rst), .mem_wr(mem_wr),
    .slow(slow), .mem_ready(mem_ready), .mem_committed(mem_committed));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    rd_q <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  // handshakes are sampled here, half a cycle clear of the edge
  always @(negedge mclk) begin
    if (rd_q) begin
      e = rq.pop_front();
      `CHK("rdata", e[31:0], reg_rdata)
    end
    if (mem_wr.valid && mem_ready && mem_wr.is_desc) begin
      e = (dq.size() != 0) ? dq.pop_front() : ~mem_wr.data;
      `CHK("wb addr", 64'h8, mem_wr.addr)
      `CHK("len csum", e[31:0], mem_wr.data[31:0])
      `CHK("status", e[39:32], mem_wr.data[39:32])
      `CHK("inexact", e[39], mem_wr.data[39])
      `CHK("errors", e[47:40], mem_wr.data[47:40])
      `CHK("tag", e[63:48], mem_wr.data[63:48])
    end else if (mem_wr.valid && mem_ready) begin
      f = (wq.size() != 0) ? wq.pop_front()
                           : ~{mem_wr.addr, mem_wr.data[15:0]};
      `CHK("snoop", exp_ns, mem_wr.no_snoop)
      `CHK("wr addr", f[79:16], mem_wr.addr)
      `CHK("wr data", {48'h0, f[15:0]}, mem_wr.data)
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    rq.push_back({32'h0, d});
  endtask
  task automatic idle;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_write <= 1'b0;
  endtask
  task automatic wt(input bit sl);
    @(negedge mclk);
    while ((sl ? desc_ready : rx_ready) !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
  endtask
  task automatic buffer(input rdwb_class_type c, input bit full);
    int          n;
    bit          hit, tg, crc, l4, hv, ip, tc, ud, inx, receive_data_error, od;
    logic [15:0] len, d;
    logic [63:0] w0, w1, ad;
    n = $urandom_range(12, 5);
    hit = ctrl[0] && c.ether_type === vt;
    hv = first && ctrl[10:8] != 3'h0;
    len = 16'h0;
    if (first)
      s = 17'h0;
    w0 = {$urandom, $urandom} | 64'h100;
    w1 = {$urandom, $urandom} | 64'h100;
    ad = ctrl[7] ? {w0[63:1], 1'b0} : w0;
    // the class must stand until the pending write-back has gone
    @(negedge mclk);
    while (desc_ready !== 1'b1 || mem_wr.valid !== 1'b0)
      @(negedge mclk);
    @(posedge mclk);
    desc_word0 <= w0;
    desc_word1 <= w1;
    desc_valid <= 1'b1;
    exp_ns = ctrl[7] & w0[0];
    @(negedge mclk);
    `CHK("hdr valid", hv, hdr_addr_valid)
    if (hv)
      `CHK("hdr addr", w1[63:1], hdr_addr[63:1])
    @(posedge mclk);
    desc_valid <= 1'b0;
    rx_class <= c;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      tg = first && (i == 1 || i == 2);
      crc = !full && i >= n - 2;
      l4 = (!first || i >= 3) && !tg;
      od = crc && i == n - 1 && $urandom_range(1) == 1;
      rx_beat <= '{1'b1, !full && i == n - 1, od, d, l4, crc, tg};
      rx_buf_full <= full && i == n - 1;
      if (!(tg && hit)) begin
        wq.push_back({ad, d});
        ad = ad + (od ? 64'h1 : 64'h2);
        len = len + (od ? 16'h1 : 16'h2);
      end
      if (l4 && !crc)
        s = {1'b0, s[15:0] + d} + (s[15:0] + {1'b0, d} > 17'hFFFF);
      wt(1'b0);
    end
    rx_beat <= '0;
    rx_buf_full <= 1'b0;
    receive_data_error = |c[4:0];
    ip = ctrl[5] && c.is_ipv4 && !(c.is_udp && c.udp_zero_csum);
    tc = ctrl[6] && c.is_tcp && (c.is_ipv4 || c.is_ipv6);
    ud = ctrl[6] && c.is_udp && (c.is_ipv4 || c.is_ipv6)
      && !(c.is_ipv4 && c.udp_zero_csum);
    inx = !c.exact_match && (c.hash_match || (c.is_ctrl_frame && !ctrl[3]))
      && !(c.is_mcast && ctrl[1]) && !(c.is_bcast && ctrl[2]);
    if (full)
      dq.push_back({24'h0, 8'h01, 16'h0, len});
    else if (!receive_data_error || ctrl[4])
      dq.push_back({hit ? c.tag : 16'h0, receive_data_error, ip && c.ip_csum_bad,
        (tc || ud) && c.l4_csum_bad, 5'h0, inx, ip, tc, ud, hit, 3'b011,
        s[15:0], len});
    first = !full;
  endtask
  initial begin
    void'($urandom(32'h03B29D77));
    {sys_rst, first} = 2'b11;
    {reg_write, reg_read, desc_valid, rx_buf_full, slow} = 5'h0;
    {reg_addr, reg_wdata, desc_word0, desc_word1, rx_beat} = '0;
    rx_class = '0;
    ctrl = 32'h0;
    vt = 16'h88A8;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h8100);
    rd(4'hF, 32'h0);
    wr(4'h1, {16'h0, vt});
    rd(4'h1, {16'h0, vt});
    idle();
    $display("registers done");
    for (int t = 0; t < 30; t++) begin
      r = {$urandom, $urandom};
      c = r[48:0];
      c.ether_type = $urandom_range(1) ? vt : 16'h0800;
      if (c.is_ipv6)
        c.is_ipv4 = 1'b0;
      if (c.is_tcp)
        c.is_udp = 1'b0;
      if (c.is_bcast || c.is_ctrl_frame)
        c.is_mcast = 1'b0;
      if (c.is_ctrl_frame)
        c.hash_match = 1'b0;
      if ($urandom_range(2) != 0 || t[0])
        c[4:0] = 5'h0;
      wt(1'b1);
      ctrl = $urandom & 32'h7FF;
      slow <= $urandom_range(1);
      wr(4'h0, ctrl);
      rd(4'h0, ctrl);
      idle();
      // error packets stay single-buffer so only the last write-back drops
      if (t[0])
        buffer(c, 1'b1);
      buffer(c, 1'b0);
      $display("packet %0d done", t);
    end
    while (dq.size() != 0 || wq.size() != 0)
      @(posedge mclk);
    rd(4'h3, 32'h0000_001E);
    rd(4'h2, 32'h0000_0006);
    idle();
    repeat (2)
      @(posedge mclk);
    wrap_up();
  end
endmodule
